/* File: src/afs_regs.vh */
// register map, field positions, reset values and timing for the arc fault supervisor
// assumes a 125 MHz clock and a 32-bit apb master
`ifndef AFS_REGS_VH
`define AFS_REGS_VH

// byte offsets
`define AFS_CFG_OFF      8'h00
`define AFS_HVREQ_OFF    8'h04
`define AFS_CMD_OFF      8'h08
`define AFS_STAT_OFF     8'h0C
`define AFS_ISTAT_OFF    8'h10
`define AFS_IMASK_OFF    8'h14

// config fields
`define AFS_CNT_LSB      0
`define AFS_WIN_LSB      8
`define AFS_QNC_LSB      16
`define AFS_RAMP_BIT     27
`define AFS_ARCEN_BIT    28
`define AFS_SKIP_BIT     29
`define AFS_DEFREM_BIT   30

// command bits
`define AFS_CMD_SAVE     0
`define AFS_CMD_REMOTE   1
`define AFS_CMD_LOCAL    2
`define AFS_CMD_CLEAR    3

// limits and defaults
`define AFS_CNT_MIN      4'h2
`define AFS_CNT_MAX      4'hA
`define AFS_CNT_DEF      4'h4
`define AFS_WIN_MIN      5'h0A
`define AFS_WIN_MAX      5'h14
`define AFS_WIN_DEF      5'h0A
`define AFS_QNC_MIN      9'h032
`define AFS_QNC_MAX      9'h12C
`define AFS_QNC_DEF      9'h096

// timing
`define AFS_CLK_NS       8
`define AFS_MS_NS        1000000
`define AFS_MS_PER_S     15'h3E8

`endif

/* File: src/afs_supervisor.v */
// arc fault supervisor: arc counting, quench, re-ramp, shutdown, local/remote mode
// assumes one 125 MHz clock, apb master, settings store on nv_* ports
//
// Functional notes
// - arc control off: first arc shuts high voltage down and stops
// - arc control on: shut down when count of arcs reached inside window
// - arc count threshold 2 to 10, default 4
// - arc window 10 to 20 seconds
// - arc window defaults to 10 seconds without saved value
// - high voltage held off for quench time 50 to 300 ms, default 150
// - after quench re-ramp, user ramps if ramp control on, else standard
// - skip option restores output after arc with no ramp
// - arc settings written to store on save, reloaded at power-up
// - power up local unless default-remote saved; otherwise remote only on command
// - saved default-remote: power up remote, local enable ignored
// - remote command while enabled locally: shut down, fault until clear
// - in remote mode enable contact is an interlock for remote enable
`timescale 1ns/1ns
`default_nettype none
`include "afs_regs.vh"

module afs_supervisor #(
    parameter CYC_PER_MS = `AFS_MS_NS / `AFS_CLK_NS
) (
    // clock and reset
    input  wire        clk,
    input  wire        rst,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // pins from the supply
    input  wire        arc_detect,
    input  wire        enable_contact,
    // settings store
    input  wire [31:0] nv_rdata,
    input  wire        nv_valid,
    output reg         nv_write,
    output reg  [31:0] nv_wdata,
    // supply control
    output reg         hv_enable,
    output reg         ramp_start,
    output reg         ramp_user,
    output reg         remote_mode,
    output reg         fault,
    output reg         irq
);

    localparam [3:0] S_OFF    = 4'b0001;
    localparam [3:0] S_ON     = 4'b0010;
    localparam [3:0] S_QUENCH = 4'b0100;
    localparam [3:0] S_FAULT  = 4'b1000;

    reg  [3:0]  state;
    reg  [3:0]  next_state;
    reg  [3:0]  cfg_cnt;
    reg  [4:0]  cfg_win;
    reg  [8:0]  cfg_qnc;
    reg         cfg_ramp;
    reg         cfg_arcen;
    reg         cfg_skip;
    reg         cfg_defrem;
    reg         hv_req;
    reg  [2:0]  int_stat;
    reg  [2:0]  int_mask;
    reg         booted;
    reg         fault_arc;
    reg         fault_mode;
    reg  [1:0]  arc_sync;
    reg         arc_prev;
    reg  [1:0]  en_sync;
    reg  [16:0] ms_div;
    reg         ms_tick;
    reg  [8:0]  qnc_ms;
    reg  [14:0] win_ms;
    reg         win_run;
    reg  [3:0]  arc_cnt;

    wire        wr_acc;
    wire        setup;
    wire        arc_ev;
    wire        run_ok;
    wire [14:0] win_lim;
    wire [31:0] cfg_word;
    wire [2:0]  ev;
    wire        cmd_wr;
    wire        cmd_clear;
    wire        cmd_remote;
    wire        cmd_local;
    wire        trip;

    // clamp a field into its legal range
    function [8:0] clampv;
        input [8:0] v;
        input [8:0] lo;
        input [8:0] hi;
        begin
            clampv = (v < lo) ? lo : ((v > hi) ? hi : v);
        end
    endfunction

    // address decode
    function mapped;
        input [7:0] a;
        begin
            mapped = (a == `AFS_CFG_OFF) || (a == `AFS_HVREQ_OFF)
                  || (a == `AFS_CMD_OFF) || (a == `AFS_STAT_OFF)
                  || (a == `AFS_ISTAT_OFF) || (a == `AFS_IMASK_OFF);
        end
    endfunction

    assign setup    = psel & ~penable;
    assign wr_acc   = psel & penable & pready & pwrite & ~pslverr;
    assign cmd_wr   = wr_acc & (paddr == `AFS_CMD_OFF);
    assign cmd_clear  = cmd_wr & pwdata[`AFS_CMD_CLEAR];
    assign cmd_remote = cmd_wr & pwdata[`AFS_CMD_REMOTE];
    assign cmd_local  = cmd_wr & pwdata[`AFS_CMD_LOCAL];
    assign cfg_word = {1'b0, cfg_defrem, cfg_skip, cfg_arcen, cfg_ramp,
                       2'b00, cfg_qnc, 3'b000, cfg_win, 4'h0, cfg_cnt};
    assign win_lim  = {10'h000, cfg_win} * `AFS_MS_PER_S;
    assign arc_ev   = arc_sync[1] & ~arc_prev & (state == S_ON);
    // a window that ends on this tick no longer counts its arcs
    wire        win_end  = win_run & ms_tick & (win_ms + 15'h0001 >= win_lim);
    wire [3:0]  arc_base = win_end ? 4'h0 : arc_cnt;
    // interlock in remote, plain enable in local
    assign run_ok   = remote_mode ? (hv_req & en_sync[1]) : en_sync[1];
    // arc shutdown: first arc when off, threshold when on
    assign trip     = ~cfg_arcen | (arc_base + 4'h1 >= cfg_cnt);
    assign ev       = {cmd_remote & ~remote_mode & (state == S_ON),
                       arc_ev & trip, arc_ev};
    wire [31:0] cfg_src  = booted ? pwdata : nv_rdata;
    wire        cfg_load = booted ? (wr_acc && paddr == `AFS_CFG_OFF) : nv_valid;
    wire [8:0]  cnt_cl   = clampv({5'h00, cfg_src[3:0]}, {5'h00, `AFS_CNT_MIN},
                                  {5'h00, `AFS_CNT_MAX});
    wire [8:0]  win_cl   = clampv({4'h0, cfg_src[12:8]}, {4'h0, `AFS_WIN_MIN},
                                  {4'h0, `AFS_WIN_MAX});
    wire [8:0]  qnc_cl   = clampv(cfg_src[24:16], `AFS_QNC_MIN, `AFS_QNC_MAX);

    // pin synchronisers
    always @(posedge clk)
    begin
        if (rst)
        begin
            arc_sync <= 2'b00;
            arc_prev <= 1'b0;
            en_sync  <= 2'b00;
        end
        else
        begin
            arc_sync <= {arc_sync[0], arc_detect};
            arc_prev <= arc_sync[1];
            en_sync  <= {en_sync[0], enable_contact};
        end
    end

    // millisecond enable
    always @(posedge clk)
    begin
        ms_tick <= ~rst & (ms_div == CYC_PER_MS[16:0] - 17'h00001);
        if (rst || ms_div == CYC_PER_MS[16:0] - 17'h00001)
            ms_div <= 17'h00000;
        else
            ms_div <= ms_div + 17'h00001;
    end

    // settings, boot load and save
    always @(posedge clk)
    begin
        if (rst)
        begin
            cfg_cnt    <= `AFS_CNT_DEF;
            cfg_win    <= `AFS_WIN_DEF;
            cfg_qnc    <= `AFS_QNC_DEF;
            cfg_ramp   <= 1'b0;
            cfg_arcen  <= 1'b0;
            cfg_skip   <= 1'b0;
            cfg_defrem <= 1'b0;
            booted     <= 1'b0;
            nv_write   <= 1'b0;
            nv_wdata   <= 32'h00000000;
            hv_req     <= 1'b0;
            int_mask   <= 3'b000;
        end
        else
        begin
            booted   <= 1'b1;
            nv_write <= 1'b0;
            if (cfg_load)
            begin
                cfg_cnt    <= cnt_cl[3:0];
                cfg_win    <= win_cl[4:0];
                cfg_qnc    <= qnc_cl;
                cfg_ramp   <= cfg_src[`AFS_RAMP_BIT];
                cfg_arcen  <= cfg_src[`AFS_ARCEN_BIT];
                cfg_skip   <= cfg_src[`AFS_SKIP_BIT];
                cfg_defrem <= cfg_src[`AFS_DEFREM_BIT];
            end
            if (cmd_wr && pwdata[`AFS_CMD_SAVE])
            begin
                nv_write <= 1'b1;
                nv_wdata <= cfg_word;
            end
            if (wr_acc && paddr == `AFS_HVREQ_OFF)
                hv_req <= pwdata[0];
            if (wr_acc && paddr == `AFS_IMASK_OFF)
                int_mask <= pwdata[2:0];
        end
    end

    // supervisor state machine
    always @*
    begin
        next_state = state;
        case (state)
            S_OFF:
                if (run_ok && booted)
                    next_state = S_ON;
            S_ON:
                if (ev[2] || (arc_ev && trip))
                    next_state = S_FAULT;
                else if (arc_ev)
                    next_state = S_QUENCH;
                else if (!run_ok)
                    next_state = S_OFF;
            S_QUENCH:
                if (!run_ok)
                    next_state = S_OFF;
                else if (ms_tick && qnc_ms + 9'h001 >= cfg_qnc)
                    next_state = S_ON;
            S_FAULT:
                if (cmd_clear)
                    next_state = S_OFF;
            default:
                next_state = S_OFF;
        endcase
    end

    always @(posedge clk)
    begin
        if (rst)
        begin
            state       <= S_OFF;
            remote_mode <= 1'b0;
            fault_arc   <= 1'b0;
            fault_mode  <= 1'b0;
            qnc_ms      <= 9'h000;
            win_ms      <= 15'h0000;
            win_run     <= 1'b0;
            arc_cnt     <= 4'h0;
            hv_enable   <= 1'b0;
            ramp_start  <= 1'b0;
            ramp_user   <= 1'b0;
            fault       <= 1'b0;
        end
        else
        begin
            state      <= next_state;
            ramp_start <= 1'b0;
            ramp_user  <= cfg_ramp;
            hv_enable  <= (next_state == S_ON);
            fault      <= fault_arc | fault_mode;
            if (!booted)
                remote_mode <= nv_valid & nv_rdata[`AFS_DEFREM_BIT];
            else if (cmd_remote)
                remote_mode <= 1'b1;
            else if (cmd_local)
                remote_mode <= 1'b0;
            if (state == S_OFF && next_state == S_ON)
                ramp_start <= 1'b1;
            if (state == S_QUENCH && next_state == S_ON)
                ramp_start <= ~cfg_skip;
            if (state == S_QUENCH && ms_tick)
                qnc_ms <= qnc_ms + 9'h001;
            else if (state != S_QUENCH)
                qnc_ms <= 9'h000;
            if (win_end)
            begin
                win_run <= 1'b0;
                arc_cnt <= 4'h0;
                win_ms  <= 15'h0000;
            end
            else if (win_run && ms_tick)
                win_ms <= win_ms + 15'h0001;
            if (arc_ev)
            begin
                arc_cnt <= arc_base + 4'h1;
                if (!win_run || win_end)
                begin
                    win_run <= 1'b1;
                    win_ms  <= 15'h0000;
                end
                if (trip)
                    fault_arc <= 1'b1;
            end
            if (ev[2])
                fault_mode <= 1'b1;
            if (cmd_clear && state == S_FAULT)
            begin
                fault_arc  <= 1'b0;
                fault_mode <= 1'b0;
                arc_cnt    <= 4'h0;
                win_run    <= 1'b0;
                win_ms     <= 15'h0000;
            end
        end
    end

    // interrupt status, set beats clear
    always @(posedge clk)
    begin
        if (rst)
        begin
            int_stat <= 3'b000;
            irq      <= 1'b0;
        end
        else
        begin
            if (wr_acc && paddr == `AFS_ISTAT_OFF)
                int_stat <= (int_stat & ~pwdata[2:0]) | ev;
            else
                int_stat <= int_stat | ev;
            irq <= |(int_stat & int_mask);
        end
    end

    // apb answer, no wait states
    always @(posedge clk)
    begin
        if (rst)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end
        else
        begin
            pready  <= setup;
            pslverr <= setup & ~mapped(paddr);
            if (setup && pwrite)
                prdata <= 32'h00000000;
            else if (setup)
            begin
                case (paddr)
                    `AFS_CFG_OFF:   prdata <= cfg_word;
                    `AFS_HVREQ_OFF: prdata <= {31'h00000000, hv_req};
                    `AFS_STAT_OFF:  prdata <= {20'h00000, arc_cnt, 1'b0,
                                               fault_mode, fault_arc, win_run,
                                               state[2], hv_enable, en_sync[1],
                                               remote_mode};
                    `AFS_ISTAT_OFF: prdata <= {29'h00000000, int_stat};
                    `AFS_IMASK_OFF: prdata <= {29'h00000000, int_mask};
                    default:        prdata <= 32'h00000000;
                endcase
            end
        end
    end

endmodule // afs_supervisor
`default_nettype wire

/* File: verif/afs_supervisor_monitor.sv */
// checker on the supervisor ports
// bound into afs_supervisor; one clock, rst synchronous high
`timescale 1ns/1ns
`default_nettype none
`include "afs_regs.vh"

module afs_supervisor_monitor (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // supply side
    input wire logic        arc_detect,
    input wire logic        enable_contact,
    input wire logic        nv_write,
    input wire logic        hv_enable,
    input wire logic        fault
);
    wire logic clr_wr = psel && penable && pwrite && pready && paddr == `AFS_CMD_OFF
                        && pwdata[`AFS_CMD_CLEAR];
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence
    a_ready_after_setup: assert property (s_setup |=> s_access)
        else $error("no answer after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready too long");
    a_refuse_zero: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("refused read not zero");
    a_save_pulse: assert property (nv_write |=> !nv_write)
        else $error("save pulse too long");
    a_fault_hv_off: assert property (fault && $past(fault) |-> !hv_enable)
        else $error("hv on in fault");
    a_contact_gate: assert property (!enable_contact [*8] |-> !hv_enable)
        else $error("hv on with contact open");
    a_arc_hv_off: assert property ($rose(arc_detect) && hv_enable |-> ##[1:8] !hv_enable)
        else $error("hv not off after arc");
    a_clear_fault: assert property ($fell(fault) |->
        $past(clr_wr) || $past(clr_wr, 2) || $past(clr_wr, 3))
        else $error("fault left without clear");
endmodule // afs_supervisor_monitor

bind afs_supervisor afs_supervisor_monitor u_mon (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .arc_detect(arc_detect), .enable_contact(enable_contact), .nv_write(nv_write),
    .hv_enable(hv_enable), .fault(fault)
);
`default_nettype wire

/* File: verif/afs_nv_model.sv */
// settings store model on the nv_* ports
// sees no reset, so the word survives a power cycle
`timescale 1ns/1ns
`default_nettype none

module afs_nv_model (
    // clock
    input  wire logic        clk,
    // store
    input  wire logic        nv_write,
    input  wire logic [31:0] nv_wdata,
    output var  logic [31:0] nv_rdata,
    output var  logic        nv_valid
);
    initial
    begin
        nv_rdata = 32'hA5C3_5A3C;
        nv_valid = 1'h0;
    end
    always @(posedge clk)
    begin
        if (nv_write === 1'h1)
        begin
            nv_rdata <= nv_wdata;
            nv_valid <= 1'h1;
        end
    end
endmodule // afs_nv_model
`default_nettype wire

/* File: verif/test_arc_fault_supervisor.sv */
// self-checking bench for the arc fault supervisor
// drives apb, arc and contact pins; settings store is a model
`timescale 1ns/1ns
`default_nettype none
`include "afs_regs.vh"
`define chk(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
    $display("Error at %0t: got %h want %h", $time, (a), (b)); end end

module test_arc_fault_supervisor;
    logic        clk = 1'h0;
    logic        rst = 1'h1;
    logic        psel = 1'h0;
    logic        penable = 1'h0;
    logic        pwrite = 1'h0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        arc_detect = 1'h0;
    logic        enable_contact = 1'h0;
    logic [31:0] q, want;
    logic        e;
    wire  [31:0] prdata, nv_rdata, nv_wdata;
    wire         pready, pslverr, nv_valid, nv_write, hv_enable;
    wire         ramp_start, ramp_user, remote_mode, fault, irq;
    integer      mismatches = 0, cmp_count = 0, ramps = 0, cyc = 0, n, r0, t0;

    afs_supervisor #(.CYC_PER_MS(10)) dut (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .arc_detect(arc_detect), .enable_contact(enable_contact),
        .nv_rdata(nv_rdata), .nv_valid(nv_valid), .nv_write(nv_write), .nv_wdata(nv_wdata),
        .hv_enable(hv_enable), .ramp_start(ramp_start), .ramp_user(ramp_user),
        .remote_mode(remote_mode), .fault(fault), .irq(irq)
    );
    afs_nv_model u_nv (.clk(clk), .nv_write(nv_write), .nv_wdata(nv_wdata),
        .nv_rdata(nv_rdata), .nv_valid(nv_valid));

    always #4 clk = ~clk;
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (ramp_start === 1'h1)
            ramps <= ramps + 1;
    end

    task stop_test;
    begin
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
    endtask

    // apb, arc and reset_dut start at a rising edge and end at a falling edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        integer k;
    begin
        @(posedge clk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        k = 0;
        do begin @(posedge clk); k++; end while (pready !== 1'h1 && k < 20);
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(negedge clk);
        if (k >= 20)
        begin
            mismatches++;
            stop_test;
        end
    end
    endtask

    // s 0 waits on hv_enable, 1 on fault
    task wait_sig(input integer s, input logic v);
    begin
        n = 0;
        do begin @(negedge clk); n++; end while ((s ? fault : hv_enable) !== v && n < 3000);
        if (n >= 3000)
        begin
            mismatches++;
            stop_test;
        end
    end
    endtask

    task arc;
    begin
        @(posedge clk);
        arc_detect <= 1'h1;
        repeat (4) @(posedge clk);
        arc_detect <= 1'h0;
        repeat (3) @(posedge clk);
        @(negedge clk);
    end
    endtask

    task reset_dut;
    begin
        @(posedge clk);
        rst <= 1'h1;
        repeat (3) @(posedge clk);
        rst <= 1'h0;
        @(negedge clk);
    end
    endtask

    task t_defaults;
    begin
        apb(1'h0, `AFS_CFG_OFF, 32'h0);
        want = (`AFS_QNC_DEF << `AFS_QNC_LSB) | (`AFS_WIN_DEF << `AFS_WIN_LSB) | `AFS_CNT_DEF;
        `chk(q, want)
        `chk(q[`AFS_ARCEN_BIT], 1'h0)
        `chk(remote_mode, 1'h0)
        apb(1'h0, 8'h18, 32'h0);
        `chk({e, q}, 33'h100000000)
        apb(1'h1, 8'h18, 32'hFFFF_FFFF);
        `chk({e, q}, 33'h100000000)
    end
    endtask

    task t_clamp;
    begin
        apb(1'h1, `AFS_CFG_OFF, 32'h01FF_1F0F);
        apb(1'h0, `AFS_CFG_OFF, 32'h0);
        `chk(q, 32'h012C_140A)
        apb(1'h1, `AFS_CFG_OFF, 32'h0);
        apb(1'h0, `AFS_CFG_OFF, 32'h0);
        `chk(q, 32'h0032_0A02)
    end
    endtask

    task t_arc_off;
    begin
        @(posedge clk);
        enable_contact <= 1'h1;
        wait_sig(0, 1'h1);
        apb(1'h1, `AFS_IMASK_OFF, 32'h0);
        arc;
        wait_sig(1, 1'h1);
        `chk(hv_enable, 1'h0)
        apb(1'h0, `AFS_ISTAT_OFF, 32'h0);
        `chk({q[1], irq}, 2'h2)
        apb(1'h1, `AFS_IMASK_OFF, 32'h2);
        @(negedge clk);
        `chk(irq, 1'h1)
        apb(1'h1, `AFS_ISTAT_OFF, 32'h7);
        @(negedge clk);
        `chk(irq, 1'h0)
        apb(1'h1, `AFS_CMD_OFF, 32'h8);
        wait_sig(1, 1'h0);
        wait_sig(0, 1'h1);
    end
    endtask

    task t_arc_count;
    begin
        apb(1'h1, `AFS_CFG_OFF, 32'h1832_0A02);
        r0 = ramps;
        t0 = cyc;
        arc;
        wait_sig(0, 1'h0);
        wait_sig(0, 1'h1);
        `chk(cyc - t0 >= 490 && cyc - t0 <= 520, 1'b1)
        apb(1'h0, `AFS_STAT_OFF, 32'h0);
        `chk(q[11:8], 4'h1)
        `chk(ramps - r0, 1)
        `chk(ramp_user, 1'h1)
        arc;
        wait_sig(1, 1'h1);
        apb(1'h1, `AFS_CMD_OFF, 32'h8);
        wait_sig(1, 1'h0);
    end
    endtask

    task t_skip;
    begin
        apb(1'h1, `AFS_CFG_OFF, 32'h3032_0A03);
        wait_sig(0, 1'h1);
        apb(1'h0, `AFS_STAT_OFF, 32'h0);
        `chk({q[11:8], q[4]}, 5'h00)
        `chk(ramp_user, 1'h0)
        r0 = ramps;
        arc;
        wait_sig(0, 1'h0);
        wait_sig(0, 1'h1);
        apb(1'h0, `AFS_STAT_OFF, 32'h0);
        `chk(ramps - r0, 0)
    end
    endtask

    task t_mode;
    begin
        `chk(remote_mode, 1'h0)
        apb(1'h1, `AFS_CMD_OFF, 32'h2);
        wait_sig(1, 1'h1);
        `chk({remote_mode, hv_enable}, 2'h2)
        apb(1'h1, `AFS_CMD_OFF, 32'h8);
        wait_sig(1, 1'h0);
        apb(1'h0, `AFS_STAT_OFF, 32'h0);
        `chk(hv_enable, 1'h0)
        apb(1'h1, `AFS_HVREQ_OFF, 32'h1);
        wait_sig(0, 1'h1);
        @(posedge clk);
        enable_contact <= 1'h0;
        wait_sig(0, 1'h0);
    end
    endtask

    task t_save;
    begin
        want = 32'h50C8_0F05;
        apb(1'h1, `AFS_CFG_OFF, want);
        apb(1'h1, `AFS_CMD_OFF, 32'h1);
        `chk(nv_wdata, want)
        apb(1'h1, `AFS_CMD_OFF, 32'h4);
        @(posedge clk);
        enable_contact <= 1'h1;
        reset_dut;
        apb(1'h0, `AFS_CFG_OFF, 32'h0);
        `chk(q, want)
        `chk({remote_mode, hv_enable}, 2'h2)
    end
    endtask

    initial
    begin
        reset_dut;
        t_defaults;
        t_clamp;
        t_arc_off;
        t_arc_count;
        t_skip;
        t_mode;
        t_save;
        stop_test;
    end
endmodule // test_arc_fault_supervisor
`default_nettype wire
